// ===== lhap_pkg.sv
// Constants, encodings and helper functions for the LCD host access port
package lhap_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 11;
    localparam int COLS = 112;
    localparam int ROWS = 10;
    localparam int RAM_DEPTH = COLS * ROWS;
    localparam logic [ADDR_W-1:0] CLEAR_LAST = 11'h45F;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    // Address layout: row in bits 10:7, column in bits 6:0
    localparam int ROW_POS = 7;
    localparam logic [3:0] ROW_LIMIT = 4'hA;
    localparam logic [6:0] COL_LIMIT = 7'h70;

    // Register select and direction encodings
    localparam logic SEL_COMMAND = 1'b0;
    localparam logic SEL_DATA = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // Command codes and masks
    localparam logic [7:0] CMD_CLEAR = 8'h01;
    localparam logic [7:0] CMD_DISP_MASK = 8'hFC;
    localparam logic [7:0] CMD_DISP = 8'h08;
    localparam logic [7:0] CMD_ENTRY_MASK = 8'hFC;
    localparam logic [7:0] CMD_ENTRY = 8'h10;
    localparam logic [7:0] CMD_ROW_MASK = 8'hF0;
    localparam logic [7:0] CMD_ROW = 8'h40;
    localparam logic [7:0] CMD_COL_MASK = 8'h80;
    localparam logic [7:0] CMD_COL = 8'h80;
    localparam int BIT_DISP_ON = 0;
    localparam int BIT_DISP_REV = 1;
    localparam int BIT_READ_ADV = 0;
    localparam int BIT_DECREMENT = 1;

    // Interface mode strap codes
    localparam logic [2:0] MODE_SERIAL = 3'h0;
    localparam logic [2:0] MODE_I2C = 3'h1;
    localparam logic [2:0] MODE_P68_8 = 3'h2;
    localparam logic [2:0] MODE_P68_4 = 3'h3;
    localparam logic [2:0] MODE_P80_8 = 3'h4;
    localparam logic [2:0] MODE_P80_4 = 3'h5;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_LOAD = 2'b11,
        ST_CLEAR = 2'b10
    } lhap_state_t;

    function automatic logic addr_valid(input logic [ADDR_W-1:0] a);
        addr_valid = (a[10:7] < ROW_LIMIT) && (a[6:0] < COL_LIMIT);
    endfunction : addr_valid

    function automatic logic [ADDR_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] rowTimes;
        rowTimes = ADDR_W'({7'h00, a[10:7]} * 11'd112);
        addr_index = rowTimes + {4'h0, a[6:0]};
    endfunction : addr_index

    function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a, input logic dec);
        addr_step = dec ? a - 11'h001 : a + 11'h001;
    endfunction : addr_step

    function automatic logic mode_four_bit(input logic [2:0] m);
        mode_four_bit = (m == MODE_P68_4) || (m == MODE_P80_4);
    endfunction : mode_four_bit
endpackage : lhap_pkg

// ===== lhap_pattern_ram.sv
// Pattern RAM storage, one byte per index, registered read
`timescale 1ns/1ns
module lhap_pattern_ram #(
    parameter int DEPTH = lhap_pkg::RAM_DEPTH,
    parameter int WIDTH = lhap_pkg::DATA_W,
    parameter int IDX_W = lhap_pkg::ADDR_W
) (
    input wire logic clk, // System clock
    input wire logic writeEnable, // Store writeData at index
    input wire logic [IDX_W-1:0] index, // Byte index
    input wire logic [WIDTH-1:0] writeData, // Byte to store
    output logic [WIDTH-1:0] readData // Byte at index, one cycle later
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Storage is not reset; the owner clears it by walking every index
    always_ff @(posedge clk) begin
        if (writeEnable && (int'(index) < DEPTH)) begin
            mem[index] <= writeData;
        end
        readData <= (int'(index) < DEPTH) ? mem[index] : '0;
    end
endmodule : lhap_pattern_ram

// ===== lhap_host_port.sv
// Host access port: command and data registers, address counter, pattern RAM
`timescale 1ns/1ns
module lhap_host_port (
    input wire logic clk, // System clock, 50 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [2:0] interfaceModeSelect, // Static interface mode straps
    input wire logic hostStrobe, // One-cycle access request
    input wire logic registerSelect, // 0 command register, 1 data port
    input wire logic readNotWrite, // 1 read, 0 write
    input wire logic [7:0] hostWriteData, // Write byte; upper nibble in 4-bit mode
    output logic [7:0] hostReadData, // Read byte; upper nibble in 4-bit mode
    output logic readValid, // Pulse: hostReadData updated
    output logic busy, // Data accesses ignored while high
    output logic [2:0] interfaceMode, // Captured interface mode
    output logic displayOn, // Display enable from display control
    output logic displayReverse, // Reversed display from display control
    output logic [10:0] addressCounter // Current address counter
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        lhap_pkg::lhap_state_t state;
        logic [lhap_pkg::ADDR_W-1:0] counter;
        logic [lhap_pkg::ADDR_W-1:0] clearIdx;
        logic [7:0] dataPort;
        logic [7:0] readData;
        logic readValid;
        logic busy;
        logic dummyPending;
        logic decrement;
        logic readAdvance;
        logic displayOn;
        logic displayReverse;
        logic [2:0] mode;
        logic captured;
        logic nibbleSecond;
        logic [3:0] nibbleHold;
    } lhap_regs_t;

    localparam lhap_regs_t REGS_RESET = '{
        state: lhap_pkg::ST_CLEAR,
        counter: lhap_pkg::ADDR_RESET,
        clearIdx: lhap_pkg::ADDR_RESET,
        dataPort: lhap_pkg::DATA_RESET,
        readData: lhap_pkg::DATA_RESET,
        readValid: 1'b0,
        busy: 1'b1,
        dummyPending: 1'b1,
        decrement: 1'b0,
        readAdvance: 1'b1,
        displayOn: 1'b0,
        displayReverse: 1'b0,
        mode: lhap_pkg::MODE_SERIAL,
        captured: 1'b0,
        nibbleSecond: 1'b0,
        nibbleHold: 4'h0
    };

    lhap_regs_t st;
    lhap_regs_t next_st;
    logic ramWe;
    logic [lhap_pkg::ADDR_W-1:0] ramIdx;
    logic [7:0] ramWData;
    logic [7:0] ramRData;

    ////////////////////////////////////////////////////////////////////////
    lhap_pattern_ram #(
        .DEPTH(lhap_pkg::RAM_DEPTH),
        .WIDTH(lhap_pkg::DATA_W),
        .IDX_W(lhap_pkg::ADDR_W)
    ) u_ram (
        .clk(clk),
        .writeEnable(ramWe),
        .index(ramIdx),
        .writeData(ramWData),
        .readData(ramRData)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic fourBit;
        logic firstHalf;
        logic [7:0] byteIn;
        logic cmdSlot;
        logic dataSlot;
        fourBit = lhap_pkg::mode_four_bit(st.mode);
        firstHalf = 1'b0;
        byteIn = hostWriteData;
        // Commands are taken in every state but clear, so instructions never wait
        cmdSlot = (st.state != lhap_pkg::ST_CLEAR) && (registerSelect == lhap_pkg::SEL_COMMAND)
            && (readNotWrite == lhap_pkg::DIR_WRITE);
        dataSlot = (st.state == lhap_pkg::ST_IDLE) && (registerSelect == lhap_pkg::SEL_DATA);
        next_st = st;
        next_st.readValid = 1'b0;
        ramWe = 1'b0;
        ramWData = 8'h00;
        ramIdx = (st.state == lhap_pkg::ST_CLEAR) ? st.clearIdx : lhap_pkg::addr_index(st.counter);

        // Straps are static; taken once, first cycle after reset release
        if (!st.captured) begin
            next_st.mode = interfaceModeSelect;
            next_st.captured = 1'b1;
        end

        if (hostStrobe && (cmdSlot || dataSlot)) begin
            // 4-bit modes pair two nibble accesses, upper first
            firstHalf = fourBit && !st.nibbleSecond;
            byteIn = fourBit ? {st.nibbleHold, hostWriteData[7:4]} : hostWriteData;
            next_st.nibbleSecond = firstHalf;
            if (readNotWrite == lhap_pkg::DIR_WRITE) begin
                next_st.nibbleHold = hostWriteData[7:4];
            end
        end

        case (st.state)
            lhap_pkg::ST_IDLE: begin
                if (hostStrobe && dataSlot
                        && readNotWrite == lhap_pkg::DIR_WRITE && !firstHalf) begin
                    next_st.dataPort = byteIn;
                    ramWData = byteIn;
                    ramWe = lhap_pkg::addr_valid(st.counter);
                    next_st.counter = lhap_pkg::addr_step(st.counter, st.decrement);
                end else if (hostStrobe && registerSelect == lhap_pkg::SEL_DATA
                        && readNotWrite == lhap_pkg::DIR_READ) begin
                    next_st.readValid = 1'b1;
                    if (firstHalf) begin
                        next_st.readData = {st.dataPort[7:4], 4'h0};
                    end else begin
                        next_st.readData = fourBit ? {st.dataPort[3:0], 4'h0} : st.dataPort;
                        // Dummy read keeps the counter and refetches it
                        if (st.dummyPending) begin
                            next_st.dummyPending = 1'b0;
                        end else if (st.readAdvance) begin
                            next_st.counter = lhap_pkg::addr_step(st.counter, st.decrement);
                        end
                        next_st.state = lhap_pkg::ST_FETCH;
                    end
                end
            end
            lhap_pkg::ST_FETCH: begin
                next_st.state = lhap_pkg::ST_LOAD;
            end
            lhap_pkg::ST_LOAD: begin
                // Out-of-map addresses read back as zero
                next_st.dataPort = lhap_pkg::addr_valid(st.counter) ? ramRData : 8'h00;
                next_st.state = lhap_pkg::ST_IDLE;
            end
            lhap_pkg::ST_CLEAR: begin
                // Walks every RAM byte; also used to initialise after reset
                ramWe = 1'b1;
                ramWData = 8'h00;
                if (st.clearIdx == lhap_pkg::CLEAR_LAST) begin
                    next_st.counter = lhap_pkg::ADDR_RESET;
                    next_st.dummyPending = 1'b1;
                    next_st.dataPort = lhap_pkg::DATA_RESET;
                    next_st.state = lhap_pkg::ST_IDLE;
                end else begin
                    next_st.clearIdx = st.clearIdx + 11'h001;
                end
            end
            default: begin
                next_st.state = lhap_pkg::ST_IDLE;
            end
        endcase

        // After the case, so an address set during a fetch restarts it
        if (hostStrobe && cmdSlot && !firstHalf) begin
            // Decoded commands take effect at once
            if (byteIn == lhap_pkg::CMD_CLEAR) begin
                next_st.state = lhap_pkg::ST_CLEAR;
                next_st.clearIdx = lhap_pkg::ADDR_RESET;
            end else if ((byteIn & lhap_pkg::CMD_DISP_MASK) == lhap_pkg::CMD_DISP) begin
                next_st.displayOn = byteIn[lhap_pkg::BIT_DISP_ON];
                next_st.displayReverse = byteIn[lhap_pkg::BIT_DISP_REV];
            end else if ((byteIn & lhap_pkg::CMD_ENTRY_MASK) == lhap_pkg::CMD_ENTRY) begin
                next_st.decrement = byteIn[lhap_pkg::BIT_DECREMENT];
                next_st.readAdvance = byteIn[lhap_pkg::BIT_READ_ADV];
            end else if ((byteIn & lhap_pkg::CMD_ROW_MASK) == lhap_pkg::CMD_ROW) begin
                next_st.counter = {byteIn[3:0], st.counter[6:0]};
                next_st.dummyPending = 1'b1;
                next_st.state = lhap_pkg::ST_FETCH;
            end else if ((byteIn & lhap_pkg::CMD_COL_MASK) == lhap_pkg::CMD_COL) begin
                next_st.counter = {st.counter[10:7], byteIn[6:0]};
                next_st.dummyPending = 1'b1;
                next_st.state = lhap_pkg::ST_FETCH;
            end
        end
        next_st.busy = (next_st.state != lhap_pkg::ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign hostReadData = st.readData;
    assign readValid = st.readValid;
    assign busy = st.busy;
    assign interfaceMode = st.mode;
    assign displayOn = st.displayOn;
    assign displayReverse = st.displayReverse;
    assign addressCounter = st.counter;
endmodule : lhap_host_port

// ===== lhap_host_port_chk.sv
// Concurrent checks on the host access port pins
`timescale 1ns/1ns
module lhap_host_port_chk (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic [2:0] interfaceModeSelect, // Straps
    input wire logic hostStrobe, // Request
    input wire logic registerSelect, // Select
    input wire logic readNotWrite, // Direction
    input wire logic [7:0] hostWriteData, // Write byte
    input wire logic [7:0] hostReadData, // Read byte
    input wire logic readValid, // Read answer
    input wire logic busy, // Busy
    input wire logic [2:0] interfaceMode, // Mode
    input wire logic displayOn, // Display on
    input wire logic displayReverse, // Reverse
    input wire logic [10:0] addressCounter // Counter
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Nibble modes answer per half, so take and cmd count byte-mode requests only
    logic byteMode, take, cmd, clearing, restart;
    int runLen;
    logic seenIdle;
    assign byteMode = interfaceMode != lhap_pkg::MODE_P68_4 && interfaceMode != lhap_pkg::MODE_P80_4;
    assign take = hostStrobe && !busy && byteMode;
    // Commands are taken during a fetch too; only the clear walk refuses them
    assign cmd = hostStrobe && byteMode && !(clearing && busy) && !registerSelect && !readNotWrite;
    // Address sets and clear open a new busy span even inside a running one
    assign restart = cmd && (hostWriteData[7] || hostWriteData[7:4] == 4'h4
        || hostWriteData == lhap_pkg::CMD_CLEAR);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runLen <= 0;
            seenIdle <= 1'b0;
            clearing <= 1'b1;
        end else begin
            runLen <= (busy && !restart) ? runLen + 1 : 0;
            if (!busy) seenIdle <= 1'b1;
            if (cmd && hostWriteData == lhap_pkg::CMD_CLEAR) begin
                clearing <= 1'b1;
            end else if (!busy) begin
                clearing <= 1'b0;
            end
        end
    end
    sequence s_set_col;
        cmd && hostWriteData[7];
    endsequence
    sequence s_fetch;
        busy [*2] ##1 !busy;
    endsequence
    ////////////////////////////////////////
    chk_read_answer: assert property (take && registerSelect && readNotWrite |=> readValid)
        else $error("Data read not answered");
    chk_valid_cause: assert property (readValid |-> $past(hostStrobe && !busy && readNotWrite))
        else $error("Read answer without a read");
    chk_nop_read: assert property (take && !registerSelect && readNotWrite |=>
        !readValid && $stable(addressCounter))
        else $error("Command read had an effect");
    chk_write_step: assert property (take && registerSelect && !readNotWrite |=>
        (addressCounter - $past(addressCounter) == 11'h001) || ($past(addressCounter) - addressCounter == 11'h001))
        else $error("Write did not step counter by one");
    chk_addr_fetch: assert property (s_set_col |=> s_fetch)
        else $error("Address set fetch span wrong");
    chk_col_load: assert property (s_set_col |=> addressCounter[6:0] == $past(hostWriteData[6:0]))
        else $error("Column not loaded");
    chk_row_load: assert property (cmd && hostWriteData[7:4] == 4'h4 |=>
        addressCounter[10:7] == $past(hostWriteData[3:0]))
        else $error("Row not loaded");
    chk_busy_span: assert property ($fell(busy) && seenIdle |-> runLen == 2 || runLen == 1120)
        else $error("Busy span wrong");
    chk_display_ctl: assert property (cmd && hostWriteData[7:2] == 6'h02 |=>
        displayOn == $past(hostWriteData[0]) && displayReverse == $past(hostWriteData[1])
        && (!busy || $past(busy)))
        else $error("Display control wrong");
    chk_refused_req: assert property (hostStrobe && busy |=> !readValid)
        else $error("Request taken while busy");
endmodule : lhap_host_port_chk
bind lhap_host_port lhap_host_port_chk u_chk (.clk(clk), .rst_n(rst_n),
    .interfaceModeSelect(interfaceModeSelect), .hostStrobe(hostStrobe), .registerSelect(registerSelect),
    .readNotWrite(readNotWrite), .hostWriteData(hostWriteData), .hostReadData(hostReadData),
    .readValid(readValid), .busy(busy), .interfaceMode(interfaceMode), .displayOn(displayOn),
    .displayReverse(displayReverse), .addressCounter(addressCounter));

// ===== lhap_host_model.sv
// Host processor model driving the access port pins
`timescale 1ns/1ns
module lhap_host_model (
    input wire logic clk, // System clock
    input wire logic readValid, // Read answer
    input wire logic [7:0] hostReadData, // Read byte
    output logic rst_n, // Reset, active low
    output logic [2:0] modeSel, // Straps
    output logic hostStrobe, // Request
    output logic registerSelect, // Select
    output logic readNotWrite, // Direction
    output logic [7:0] hostWriteData // Write byte
);
    initial begin
        rst_n = 1'b0;
        modeSel = lhap_pkg::MODE_P80_8;
        hostStrobe = 1'b0;
        registerSelect = 1'b0;
        readNotWrite = 1'b0;
        hostWriteData = 8'hA5;
    end
    task automatic hold_reset;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask : hold_reset
    // Straps only change while reset is held, so the device sees them static
    task automatic restrap(input logic [2:0] m);
        rst_n = 1'b0;
        modeSel = m;
        hold_reset();
    endtask : restrap
    // Keep holds the strobe so the next call lands in the very next cycle
    task automatic acc(input logic sel, input logic rd, input logic [7:0] d, input logic keep,
        output logic [7:0] q, output logic v);
        hostStrobe = 1'b1;
        registerSelect = sel;
        readNotWrite = rd;
        hostWriteData = d;
        @(posedge clk);
        #1 q = hostReadData;
        v = readValid;
        if (!keep) begin
            hostStrobe = 1'b0;
            hostWriteData = ~d; // Released bus must not keep the old value
            @(posedge clk);
            #1;
        end
    endtask : acc
endmodule : lhap_host_model

// ===== lhap_host_port_tb.sv
// Self-checking testbench for the LCD host access port
`timescale 1ns/1ns
module lhap_host_port_tb;
    logic clk, rst_n, hostStrobe, registerSelect, readNotWrite, readValid, busy, displayOn, displayReverse;
    logic [2:0] modeSel, interfaceMode;
    logic [7:0] hostWriteData, hostReadData, q;
    logic [10:0] addressCounter;
    logic v;
    int fail_count = 0;
    int n_tests = 0;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    lhap_host_model host (.clk(clk), .readValid(readValid), .hostReadData(hostReadData), .rst_n(rst_n),
        .modeSel(modeSel), .hostStrobe(hostStrobe), .registerSelect(registerSelect),
        .readNotWrite(readNotWrite), .hostWriteData(hostWriteData));
    lhap_host_port DUT (.clk(clk), .rst_n(rst_n), .interfaceModeSelect(modeSel), .hostStrobe(hostStrobe),
        .registerSelect(registerSelect), .readNotWrite(readNotWrite), .hostWriteData(hostWriteData),
        .hostReadData(hostReadData), .readValid(readValid), .busy(busy), .interfaceMode(interfaceMode),
        .displayOn(displayOn), .displayReverse(displayReverse), .addressCounter(addressCounter));
    ////////////////////////////////////////
    task automatic close_out;
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1300) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 1300) chk("busy", 11'h000, 11'h001);
    endtask : wait_idle
    task automatic cmd(input logic [7:0] c, input logic keep);
        host.acc(1'b0, 1'b0, c, keep, q, v);
        if (!keep) wait_idle();
    endtask : cmd
    task automatic rd(input logic [7:0] exp, input logic judge);
        host.acc(1'b1, 1'b1, 8'h00, 1'b0, q, v);
        chk("readValid", 11'h001, 11'(v));
        if (judge) chk("read data", 11'(exp), 11'(q));
        wait_idle();
    endtask : rd
    ////////////////////////////////////////
    task automatic t_reset;
        host.hold_reset();
        chk("busy in reset", 11'h001, 11'(busy));
        chk("counter in reset", 11'h000, addressCounter);
        wait_idle();
        chk("mode", 11'(lhap_pkg::MODE_P80_8), 11'(interfaceMode));
    endtask : t_reset
    task automatic t_stream;
        cmd(8'h90, 1'b1);
        host.acc(1'b1, 1'b0, 8'hEE, 1'b0, q, v);
        wait_idle();
        host.acc(1'b1, 1'b0, 8'h3C, 1'b1, q, v);
        host.acc(1'b1, 1'b0, 8'hC3, 1'b1, q, v);
        host.acc(1'b1, 1'b0, 8'h5A, 1'b0, q, v);
        chk("counter after writes", 11'h013, addressCounter);
        cmd(8'h90, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h3C, 1'b1);
        rd(8'hC3, 1'b1);
        rd(8'h5A, 1'b1);
        chk("counter after reads", 11'h013, addressCounter);
        host.acc(1'b0, 1'b1, 8'h00, 1'b0, q, v);
        chk("command read answer", 11'h000, 11'(v));
        chk("counter after nop", 11'h013, addressCounter);
    endtask : t_stream
    task automatic t_down;
        cmd(8'h12, 1'b1);
        cmd(8'h0B, 1'b0);
        chk("display on", 11'h001, 11'(displayOn));
        chk("display reverse", 11'h001, 11'(displayReverse));
        cmd(8'h41, 1'b1);
        cmd(8'hA0, 1'b0);
        chk("counter set", 11'h0A0, addressCounter);
        host.acc(1'b1, 1'b0, 8'h96, 1'b0, q, v);
        chk("counter down", 11'h09F, addressCounter);
        cmd(8'hA0, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h96, 1'b1);
        rd(8'h96, 1'b1);
        chk("counter held", 11'h0A0, addressCounter);
        cmd(8'h11, 1'b1);
        cmd(8'h08, 1'b0);
        chk("display off", 11'h000, 11'({displayOn, displayReverse}));
    endtask : t_down
    task automatic t_clear;
        cmd(8'h01, 1'b0);
        chk("counter cleared", 11'h000, addressCounter);
        cmd(8'h90, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h00, 1'b1);
    endtask : t_clear
    task automatic t_nibble;
        host.restrap(lhap_pkg::MODE_P80_4);
        chk("busy after restrap", 11'h001, 11'(busy));
        wait_idle();
        chk("nibble mode", 11'(lhap_pkg::MODE_P80_4), 11'(interfaceMode));
        cmd(8'h90, 1'b1);
        cmd(8'h00, 1'b0);
        host.acc(1'b1, 1'b0, 8'hB0, 1'b1, q, v);
        host.acc(1'b1, 1'b0, 8'h70, 1'b0, q, v);
        chk("nibble write step", 11'h011, addressCounter);
        cmd(8'h90, 1'b1);
        cmd(8'h00, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'h00, 1'b0);
        rd(8'hB0, 1'b1);
        rd(8'h70, 1'b1);
        chk("nibble read step", 11'h011, addressCounter);
    endtask : t_nibble
    ////////////////////////////////////////
    initial begin
        t_reset();
        t_stream();
        t_down();
        t_clear();
        t_nibble();
        close_out();
    end
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule : lhap_host_port_tb
